// File: hw/dcie_defines.vh
// Register map, field positions and reset values of the completion
// interrupt enable and queued-event clear block.
// Assumes byte addresses on a 32-bit Avalon-MM slave port.
`ifndef DCIE_DEFINES_VH
`define DCIE_DEFINES_VH

`define DCIE_ADDR_W 8
`define DCIE_DATA_W 32
`define DCIE_CHAN_N 64
`define DCIE_CODE_W 6

`define DCIE_OFF_LATCH_LO 8'h00
`define DCIE_OFF_LATCH_HI 8'h04
`define DCIE_OFF_QCLR_LO 8'h08
`define DCIE_OFF_QCLR_HI 8'h0C
`define DCIE_OFF_IEN_LO 8'h10
`define DCIE_OFF_IEN_HI 8'h14
`define DCIE_OFF_ISET_LO 8'h18
`define DCIE_OFF_ISET_HI 8'h1C
`define DCIE_OFF_ICLR_LO 8'h20
`define DCIE_OFF_ICLR_HI 8'h24
`define DCIE_OFF_PEND_LO 8'h28
`define DCIE_OFF_PEND_HI 8'h2C
`define DCIE_OFF_PCLR_LO 8'h30
`define DCIE_OFF_PCLR_HI 8'h34
`define DCIE_OFF_STAT 8'h38
`define DCIE_OFF_MASK 8'h3C

`define DCIE_ST_COMPLETE 0
`define DCIE_ST_DROPPED 1
`define DCIE_ST_UNMAPPED 2
`define DCIE_ST_W 3

`define DCIE_RST_WORD 32'h00000000
`define DCIE_RST_CHAN 64'h0000000000000000
`define DCIE_RST_STAT 3'h0
`define DCIE_RD_UNMAPPED 32'h00000000

`endif

// File: hw/dcie_bank.v
// Bank of per-channel flags with separate set and clear strobes.
// Assumes one clock; the clear strobe wins over a set in the same cycle.
`timescale 1ns/1ps

module dcie_bank #(
  parameter WIDTH = 64
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] set_in,
  input wire [WIDTH-1:0] clear_in,
  output wire [WIDTH-1:0] bits_out
);

  reg [WIDTH-1:0] bits_reg;
  wire [WIDTH-1:0] bits_next;

  assign bits_next = (bits_reg | set_in) & ~clear_in;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bits_reg <= {WIDTH{1'b0}};
    end else begin
      bits_reg <= bits_next;
    end
  end

  assign bits_out = bits_reg;

endmodule

// File: hw/dcie_top.v
// Queued-event latches, completion pending bits and completion interrupt
// enables for 64 channels, reached over an Avalon-MM slave port.
// Assumes all inputs are synchronous to clk_in.
//
// Contract
// - A one written to bit n of queued_event_clear_low clears latch n.
// - A one written to bit n of queued_event_clear_high clears latch n+32.
// - Both queued-event clear registers are write-only and read as zero.
// - A finished channel whose entry asks for it raises completion.
// - The enable registers change only through their set and clear words.
// - A one written to an enable-set bit sets that channel's enable.
// - A one written to an enable-clear bit clears that enable.
// - Bit n of completion_irq_enable_low enables channel n.
// - Bit n of completion_irq_enable_high enables channel n+32.
// - Both enable registers are read-only and reset to zero.
// - Bit n of completion_irq_enable_clear_low acts on channel n.
// - A channel whose latch is set is not granted further events.
// - A completion code n sets pending bit n until software clears it.
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "dcie_defines.vh"

module dcie_top #(
  parameter CHAN_N = `DCIE_CHAN_N,
  parameter CODE_W = `DCIE_CODE_W
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output wire [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  input wire [CHAN_N-1:0] event_req_in,
  input wire [CHAN_N-1:0] latch_hw_clear_in,
  input wire completion_valid_in,
  input wire completion_req_in,
  input wire [CODE_W-1:0] completion_code_in,
  output wire [CHAN_N-1:0] event_grant_out,
  output wire completion_irq_out,
  output wire irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Expands byte enables to a bit mask over one data word.
  function [31:0] lane_mask;
    input [3:0] be;
    integer i;
    begin
      lane_mask = 32'h00000000;
      for (i = 0; i < 32; i = i + 1) begin
        lane_mask[i] = be[i / 8];
      end
    end
  endfunction

  // Write data of an accepted write to one offset, zero otherwise.
  function [31:0] wr_word;
    input hit;
    input [31:0] data;
    input [3:0] be;
    begin
      wr_word = hit ? (data & lane_mask(be)) : 32'h00000000;
    end
  endfunction

  // One-hot decode of a completion code onto the channel vector.
  function [CHAN_N-1:0] code_onehot;
    input [CODE_W-1:0] code;
    integer i;
    begin
      code_onehot = {CHAN_N{1'b0}};
      for (i = 0; i < CHAN_N; i = i + 1) begin
        code_onehot[i] = (code == i[CODE_W-1:0]);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: every request waits one cycle, then is answered.

  reg ack_reg;
  wire req;
  wire accept;
  wire wr_acc;
  wire rd_acc;

  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_reg;
  assign accept = req & ack_reg;
  assign wr_acc = avs_write_in & ack_reg;
  assign rd_acc = avs_read_in & ack_reg;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode.

  wire [7:0] a;
  reg mapped;

  assign a = avs_address_in;

  always @* begin
    if (a == `DCIE_OFF_LATCH_LO || a == `DCIE_OFF_LATCH_HI) begin
      mapped = 1'b1;
    end else if (a == `DCIE_OFF_QCLR_LO || a == `DCIE_OFF_QCLR_HI) begin
      mapped = 1'b1;
    end else if (a == `DCIE_OFF_IEN_LO || a == `DCIE_OFF_IEN_HI) begin
      mapped = 1'b1;
    end else if (a == `DCIE_OFF_ISET_LO || a == `DCIE_OFF_ISET_HI) begin
      mapped = 1'b1;
    end else if (a == `DCIE_OFF_ICLR_LO || a == `DCIE_OFF_ICLR_HI) begin
      mapped = 1'b1;
    end else if (a == `DCIE_OFF_PEND_LO || a == `DCIE_OFF_PEND_HI) begin
      mapped = 1'b1;
    end else if (a == `DCIE_OFF_PCLR_LO || a == `DCIE_OFF_PCLR_HI) begin
      mapped = 1'b1;
    end else if (a == `DCIE_OFF_STAT || a == `DCIE_OFF_MASK) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write strobes of the write-only command words.

  wire [31:0] d;
  wire [3:0] be;
  wire [CHAN_N-1:0] qclr;
  wire [CHAN_N-1:0] iset;
  wire [CHAN_N-1:0] iclr;
  wire [CHAN_N-1:0] pclr;

  assign d = avs_writedata_in;
  assign be = avs_byteenable_in;

  assign qclr = {wr_word(wr_acc && a == `DCIE_OFF_QCLR_HI, d, be),
                 wr_word(wr_acc && a == `DCIE_OFF_QCLR_LO, d, be)};

  assign iset = {wr_word(wr_acc && a == `DCIE_OFF_ISET_HI, d, be),
                 wr_word(wr_acc && a == `DCIE_OFF_ISET_LO, d, be)};

  assign iclr = {wr_word(wr_acc && a == `DCIE_OFF_ICLR_HI, d, be),
                 wr_word(wr_acc && a == `DCIE_OFF_ICLR_LO, d, be)};

  assign pclr = {wr_word(wr_acc && a == `DCIE_OFF_PCLR_HI, d, be),
                 wr_word(wr_acc && a == `DCIE_OFF_PCLR_LO, d, be)};

  ////////////////////////////////////////////////////////////////////////
  // Queued-event latches and event grant.

  wire [CHAN_N-1:0] latch;
  wire [CHAN_N-1:0] grant;
  reg [CHAN_N-1:0] grant_reg;

  assign grant = event_req_in & ~latch;

  dcie_bank #(.WIDTH(CHAN_N)) u_latch (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_in(grant),
    .clear_in(qclr | latch_hw_clear_in),
    .bits_out(latch)
  );

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      grant_reg <= `DCIE_RST_CHAN;
    end else begin
      grant_reg <= grant;
    end
  end

  assign event_grant_out = grant_reg;

  ////////////////////////////////////////////////////////////////////////
  // Completion enables and pending bits.

  wire [CHAN_N-1:0] enable;
  wire [CHAN_N-1:0] pending;
  wire [CHAN_N-1:0] pset;
  wire comp_hit;

  // enables only via set and clear.
  dcie_bank #(.WIDTH(CHAN_N)) u_enable (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_in(iset),
    .clear_in(iclr),
    .bits_out(enable)
  );

  assign comp_hit = completion_valid_in & completion_req_in;
  assign pset = comp_hit ? code_onehot(completion_code_in) :
                {CHAN_N{1'b0}};

  dcie_bank #(.WIDTH(CHAN_N)) u_pending (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_in(pset),
    .clear_in(pclr),
    .bits_out(pending)
  );

  reg comp_irq_reg;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      comp_irq_reg <= 1'b0;
    end else begin
      comp_irq_reg <= |(pending & enable);
    end
  end

  assign completion_irq_out = comp_irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Sticky status, mask and summary interrupt.

  reg [`DCIE_ST_W-1:0] stat_reg;
  reg [`DCIE_ST_W-1:0] stat_next;
  reg [`DCIE_ST_W-1:0] mask_reg;
  reg [`DCIE_ST_W-1:0] mask_next;
  reg irq_reg;
  reg [31:0] rdata_reg;
  wire [`DCIE_ST_W-1:0] stat_evt;
  wire [31:0] mask_wr;

  assign stat_evt[`DCIE_ST_COMPLETE] = comp_hit;
  assign stat_evt[`DCIE_ST_DROPPED] = |(event_req_in & latch);
  assign stat_evt[`DCIE_ST_UNMAPPED] = accept & ~mapped;
  assign mask_wr = lane_mask(be);

  // A read of the status word clears only the bits it returned, so an
  // event that lands while the read waits is kept for the next read.
  always @* begin
    stat_next = stat_reg;
    if (rd_acc && a == `DCIE_OFF_STAT) begin
      stat_next = stat_reg & ~rdata_reg[`DCIE_ST_W-1:0];
    end
    stat_next = stat_next | stat_evt;
    mask_next = mask_reg;
    if (wr_acc && a == `DCIE_OFF_MASK) begin
      mask_next = (mask_reg & ~mask_wr[`DCIE_ST_W-1:0]) |
                  (d[`DCIE_ST_W-1:0] & mask_wr[`DCIE_ST_W-1:0]);
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_reg <= `DCIE_RST_STAT;
      mask_reg <= `DCIE_RST_STAT;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg <= |(stat_next & mask_next);
    end
  end

  assign irq_out = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read data, captured in the waiting cycle and held for the answer.

  reg [31:0] rdata_next;

  always @* begin
    if (a == `DCIE_OFF_LATCH_LO) begin
      rdata_next = latch[31:0];
    end else if (a == `DCIE_OFF_LATCH_HI) begin
      rdata_next = latch[63:32];
    end else if (a == `DCIE_OFF_IEN_LO) begin
      rdata_next = enable[31:0];
    end else if (a == `DCIE_OFF_IEN_HI) begin
      rdata_next = enable[63:32];
    end else if (a == `DCIE_OFF_PEND_LO) begin
      rdata_next = pending[31:0];
    end else if (a == `DCIE_OFF_PEND_HI) begin
      rdata_next = pending[63:32];
    end else if (a == `DCIE_OFF_STAT) begin
      rdata_next = {{(32-`DCIE_ST_W){1'b0}}, stat_reg};
    end else if (a == `DCIE_OFF_MASK) begin
      rdata_next = {{(32-`DCIE_ST_W){1'b0}}, mask_reg};
    end else begin
      rdata_next = `DCIE_RD_UNMAPPED;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= `DCIE_RST_WORD;
    end else if (avs_read_in && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata_out = rdata_reg;

endmodule

// File: sim/dcie_cpl_model.sv
// Completion source standing in for the transfer side and the CPU.
// Assumes one clock shared with the block.
`timescale 1ns/1ps
module dcie_cpl_model (
  input wire clk_in,
  input wire rst_n_in,
  input wire fire_in,
  input wire want_in,
  input wire [5:0] code_in,
  output reg valid_out,
  output reg req_out,
  output reg [5:0] code_out
);
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      valid_out <= 1'h0;
      req_out <= 1'h0;
      code_out <= 6'h00;
    end else begin
      valid_out <= fire_in;
      req_out <= fire_in & want_in;
      code_out <= fire_in ? code_in : ~code_out;
    end
  end
endmodule

// File: sim/dcie_top_sva.sv
// Port checker for dcie_top.
// Assumes it is bound into dcie_top.
`timescale 1ns/1ps
module dcie_top_sva #(
  parameter CHAN_N = 64,
  parameter CODE_W = 6
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire [CHAN_N-1:0] event_req_in,
  input wire [CHAN_N-1:0] latch_hw_clear_in,
  input wire completion_valid_in,
  input wire completion_req_in,
  input wire [CODE_W-1:0] completion_code_in,
  input wire [CHAN_N-1:0] event_grant_out,
  input wire completion_irq_out
);
  reg seen_wr;
  wire rd_ok = avs_read_in & ~avs_waitrequest_out;
  wire [4:0] blk = avs_address_in[7:3];
  wire wo = blk == 5'h01 || blk == 5'h03 || blk == 5'h04 || blk == 5'h06;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      seen_wr <= 1'h0;
    else if (avs_write_in)
      seen_wr <= 1'h1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////
  property p_wait;
    $rose(avs_read_in | avs_write_in) |->
      avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait) else $error("wait not one cycle");
  property p_gnt_req;
    (event_grant_out & ~$past(event_req_in)) == '0;
  endproperty
  a_gnt_req: assert property (p_gnt_req) else $error("grant no req");
  property p_regrant;
    event_grant_out[0] && !$past(latch_hw_clear_in[0]) &&
      !$past(avs_write_in) |=> !event_grant_out[0];
  endproperty
  a_regrant: assert property (p_regrant) else $error("regrant");
  property p_irq_rise;
    $rose(completion_irq_out) |-> $past(avs_write_in, 2) ||
      $past(completion_valid_in & completion_req_in, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rise");
  property p_irq_fall;
    $fell(completion_irq_out) |-> $past(avs_write_in, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fall");
  property p_wo_zero;
    rd_ok && wo |-> avs_readdata_out == 32'h0;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("wo read");
  property p_en_rst;
    rd_ok && !seen_wr && blk == 5'h02 |-> avs_readdata_out == 32'h0;
  endproperty
  a_en_rst: assert property (p_en_rst) else $error("enable reset");
  property p_no_en;
    !seen_wr |-> !completion_irq_out;
  endproperty
  a_no_en: assert property (p_no_en) else $error("irq unenabled");
  c_irq: cover property ($rose(completion_irq_out));
  c_gnt: cover property (event_grant_out != '0);
  c_rd: cover property (rd_ok && avs_readdata_out != 32'h0);
endmodule

// File: sim/dcie_top_tb.sv
// Self-checking bench for dcie_top with a completion source model.
// Assumes design, model and checker are compiled before it.
`timescale 1ns/1ps
module dcie_top_tb;
  logic clk_in, rst_n_in, rd, wr, fire, want;
  logic [7:0] adr;
  logic [31:0] wd, rdv;
  logic [63:0] ev, hc;
  logic [5:0] code;
  wire [31:0] rdata;
  wire wt, cv, cr, cirq, irq;
  wire [5:0] cc;
  wire [63:0] gnt;
  int mismatches, tests_run;
  dcie_top u_dcie_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
    .event_req_in(ev), .latch_hw_clear_in(hc), .completion_valid_in(cv),
    .completion_req_in(cr), .completion_code_in(cc),
    .event_grant_out(gnt), .completion_irq_out(cirq), .irq_out(irq));
  dcie_cpl_model u_dcie_cpl_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .fire_in(fire), .want_in(want), .code_in(code), .valid_out(cv),
    .req_out(cr), .code_out(cc));
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge clk_in);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wt !== 1'h0 && n < 20);
    if (wt !== 1'h0) begin
      mismatches++;
      conclude();
    end
    rdv = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rdv, e);
  endtask
  task automatic pulse(input logic [63:0] v);
    @(posedge clk_in);
    ev <= v;
    @(posedge clk_in);
    ev <= 64'h0;
    @(negedge clk_in);
  endtask
  task automatic cpl(input logic w, input logic [5:0] c);
    @(posedge clk_in);
    fire <= 1'h1;
    want <= w;
    code <= c;
    @(posedge clk_in);
    fire <= 1'h0;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_enable;
    rchk(8'h10, 32'h0);
    rchk(8'h14, 32'h0);
    rchk(8'h08, 32'h0);
    rchk(8'h0C, 32'h0);
    bus(1'h1, 8'h18, 32'h80000001);
    rchk(8'h10, 32'h80000001);
    bus(1'h1, 8'h10, 32'hFFFFFFFF);
    rchk(8'h10, 32'h80000001);
    bus(1'h1, 8'h1C, 32'h00000004);
    rchk(8'h14, 32'h00000004);
    bus(1'h1, 8'h20, 32'h00000001);
    rchk(8'h10, 32'h80000000);
    bus(1'h1, 8'h20, 32'h0);
    rchk(8'h10, 32'h80000000);
    bus(1'h1, 8'h24, 32'h00000004);
    rchk(8'h14, 32'h0);
  endtask
  task automatic t_irq;
    cpl(1'h0, 6'h1F);
    rchk(8'h28, 32'h0);
    cpl(1'h1, 6'h00);
    rchk(8'h28, 32'h00000001);
    chk(cirq, 1'h0);
    cpl(1'h1, 6'h1F);
    chk(cirq, 1'h1);
    bus(1'h1, 8'h30, 32'h80000000);
    rchk(8'h28, 32'h00000001);
    chk(cirq, 1'h0);
  endtask
  task automatic t_latch;
    pulse(64'h0000010000000008);
    chk(gnt, 64'h0000010000000008);
    rchk(8'h04, 32'h00000100);
    pulse(64'h0000010000000008);
    chk(gnt, 64'h0);
    bus(1'h1, 8'h08, 32'h0);
    rchk(8'h00, 32'h00000008);
    bus(1'h1, 8'h08, 32'h00000008);
    rchk(8'h00, 32'h0);
    bus(1'h1, 8'h0C, 32'h00000100);
    rchk(8'h04, 32'h0);
    pulse(64'h0000000000000008);
    chk(gnt, 64'h0000000000000008);
    @(posedge clk_in);
    ev <= 64'h0000000000000020;
    hc <= 64'h0000000000000020;
    @(posedge clk_in);
    ev <= 64'h0;
    hc <= 64'h0000000000000008;
    @(posedge clk_in);
    hc <= 64'h0;
    rchk(8'h00, 32'h0);
  endtask
  task automatic t_status;
    rchk(8'h38, 32'h00000003);
    rchk(8'h38, 32'h0);
    cpl(1'h1, 6'h02);
    chk(irq, 1'h0);
    bus(1'h1, 8'h3C, 32'h00000001);
    @(negedge clk_in);
    chk(irq, 1'h1);
    rchk(8'h38, 32'h00000001);
    @(negedge clk_in);
    chk(irq, 1'h0);
    rchk(8'h40, 32'h0);
    rchk(8'h38, 32'h00000004);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    rst_n_in = 1'h0;
    {rd, wr, fire, want, adr, wd, ev, hc, code} = '0;
    mismatches = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'h1;
    t_enable();
    t_irq();
    t_latch();
    t_status();
    conclude();
  end
endmodule
bind dcie_top dcie_top_sva #(.CHAN_N(CHAN_N), .CODE_W(CODE_W)) u_sva (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .event_req_in(event_req_in),
  .latch_hw_clear_in(latch_hw_clear_in),
  .completion_valid_in(completion_valid_in),
  .completion_req_in(completion_req_in),
  .completion_code_in(completion_code_in),
  .event_grant_out(event_grant_out),
  .completion_irq_out(completion_irq_out));
